// File: core/meter_status_pkg.sv
// status summary register sets of a two-channel power meter: shared constants
// assumes one 10 MHz clock and a command interpreter that issues register accesses
package meter_status_pkg;
   // ==========================================================
   // register sets
   localparam int          NSET          = 9;
   localparam int          SET_W         = 4;
   localparam logic [3:0]  SET_RUN_TOP   = 4'h0;
   localparam logic [3:0]  SET_LLF       = 4'h1;
   localparam logic [3:0]  SET_ULF       = 4'h2;
   localparam logic [3:0]  SET_ACQ       = 4'h3;
   localparam logic [3:0]  SET_SNS       = 4'h4;
   localparam logic [3:0]  SET_ARM       = 4'h5;
   localparam logic [3:0]  SET_DQ_TOP    = 4'h6;
   localparam logic [3:0]  SET_ADJ       = 4'h7;
   localparam logic [3:0]  SET_PWR       = 4'h8;
   // ==========================================================
   // registers inside a set
   localparam int          REG_W         = 3;
   localparam logic [2:0]  REG_COND      = 3'h0;
   localparam logic [2:0]  REG_EVENT     = 3'h1;
   localparam logic [2:0]  REG_ENABLE    = 3'h2;
   localparam logic [2:0]  REG_RISE      = 3'h3;
   localparam logic [2:0]  REG_FALL      = 3'h4;
   // ==========================================================
   // widths and reset / preset values
   localparam int          DATA_W        = 16;
   localparam int          STORE_W       = 15;
   localparam logic [14:0] EN_PRESET_TOP = 15'h0000;
   localparam logic [14:0] EN_PRESET_OTH = 15'h7fff;
   localparam logic [14:0] RISE_PRESET   = 15'h7fff;
   localparam logic [14:0] FALL_PRESET   = 15'h0000;
   // ==========================================================
   // bit positions
   localparam int          BIT_CH_A      = 1;
   localparam int          BIT_CH_B      = 2;
   localparam int          LLF_LO        = 1;
   localparam int          LLF_N         = 6;
   localparam int          ULF_N         = 4;
   localparam int          TOP_ACQ       = 4;
   localparam int          TOP_ARM       = 5;
   localparam int          TOP_SNS       = 10;
   localparam int          TOP_LLF       = 11;
   localparam int          TOP_ULF       = 12;
   localparam int          DQ_PWR        = 3;
   localparam int          DQ_ADJ        = 8;
   localparam int          DQ_SELFTEST   = 9;
endpackage

// File: core/meter_status_regs.sv
// status summary register sets: condition, event, rise/fall filter and enable
// assumes synchronous single-cycle status pulses and one command per cycle
`timescale 1ns/1ns
`default_nettype none

module meter_status_regs (
   input  wire logic                                  clk_i,
   input  wire logic                                  rst_n_i,
   input  wire logic                                  cmd_valid_i,
   input  wire logic                                  cmd_write_i,
   input  wire logic [meter_status_pkg::SET_W-1:0]    cmd_set_i,
   input  wire logic [meter_status_pkg::REG_W-1:0]    cmd_reg_i,
   input  wire logic [meter_status_pkg::DATA_W-1:0]   cmd_wdata_i,
   input  wire logic                                  preset_i,
   input  wire logic [meter_status_pkg::LLF_N-1:0]    ll_fail_i,
   input  wire logic [meter_status_pkg::LLF_N-1:0]    ll_pass_i,
   input  wire logic [meter_status_pkg::LLF_N-1:0]    ll_test_en_i,
   input  wire logic [meter_status_pkg::ULF_N-1:0]    ul_fail_i,
   input  wire logic [meter_status_pkg::ULF_N-1:0]    ul_pass_i,
   input  wire logic [meter_status_pkg::ULF_N-1:0]    ul_test_en_i,
   input  wire logic [1:0]                            acq_active_i,
   input  wire logic [1:0]                            sensor_read_i,
   input  wire logic [1:0]                            arm_wait_i,
   input  wire logic [meter_status_pkg::STORE_W-1:0]  pwr_cond_i,
   input  wire logic [1:0]                            adj_err_i,
   input  wire logic                                  adj_err_all_i,
   input  wire logic [1:0]                            adj_ok_i,
   input  wire logic                                  selftest_fail_i,
   input  wire logic                                  selftest_pass_i,
   output logic                                       rsp_valid_o,
   output logic      [meter_status_pkg::DATA_W-1:0]   rsp_data_o,
   output logic      [meter_status_pkg::NSET-1:0]     summary_o
);
   import meter_status_pkg::*;

   // ==========================================================
   // sticky condition sources
   logic [LLF_N-1:0]           ll_r;
   logic [ULF_N-1:0]           ul_r;
   logic [1:0]                 adj_r;
   logic                       post_r;
   logic [LLF_N-1:0]           ll_nxt;
   logic [ULF_N-1:0]           ul_nxt;
   logic [1:0]                 adj_nxt;
   logic                       post_nxt;

   assign ll_nxt   = ll_fail_i | (ll_r & ~(ll_pass_i & ll_test_en_i));
   assign ul_nxt   = ul_fail_i | (ul_r & ~(ul_pass_i & ul_test_en_i));
   assign adj_nxt  = adj_err_i | {2{adj_err_all_i}} | (adj_r & ~adj_ok_i);
   assign post_nxt = selftest_fail_i | (post_r & ~selftest_pass_i);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ll_r   <= '0;
         ul_r   <= '0;
         adj_r  <= '0;
         post_r <= 1'b0;
      end else begin
         ll_r   <= ll_nxt;
         ul_r   <= ul_nxt;
         adj_r  <= adj_nxt;
         post_r <= post_nxt;
      end
   end

   // ==========================================================
   // condition vectors per set
   logic [NSET-1:0][STORE_W-1:0] cond_w;
   logic [NSET-1:0]              sum_w;

   always_comb begin
      cond_w = '0;
      cond_w[SET_LLF][LLF_LO +: LLF_N]    = ll_r;
      cond_w[SET_ULF][LLF_LO +: ULF_N]    = ul_r;
      cond_w[SET_ACQ][BIT_CH_A]           = acq_active_i[0];
      cond_w[SET_ACQ][BIT_CH_B]           = acq_active_i[1];
      cond_w[SET_SNS][BIT_CH_A]           = sensor_read_i[0];
      cond_w[SET_SNS][BIT_CH_B]           = sensor_read_i[1];
      cond_w[SET_ARM][BIT_CH_A]           = arm_wait_i[0];
      cond_w[SET_ARM][BIT_CH_B]           = arm_wait_i[1];
      cond_w[SET_ADJ][BIT_CH_A]           = adj_r[0];
      cond_w[SET_ADJ][BIT_CH_B]           = adj_r[1];
      cond_w[SET_PWR]                     = pwr_cond_i;
      cond_w[SET_RUN_TOP][TOP_ACQ]        = sum_w[SET_ACQ];
      cond_w[SET_RUN_TOP][TOP_ARM]        = sum_w[SET_ARM];
      cond_w[SET_RUN_TOP][TOP_SNS]        = sum_w[SET_SNS];
      cond_w[SET_RUN_TOP][TOP_LLF]        = sum_w[SET_LLF];
      cond_w[SET_RUN_TOP][TOP_ULF]        = sum_w[SET_ULF];
      cond_w[SET_DQ_TOP][DQ_PWR]          = sum_w[SET_PWR];
      cond_w[SET_DQ_TOP][DQ_ADJ]          = sum_w[SET_ADJ];
      cond_w[SET_DQ_TOP][DQ_SELFTEST]     = post_r;
   end

   // ==========================================================
   // per-set event, enable and filter registers
   logic [NSET-1:0][STORE_W-1:0] event_w;
   logic [NSET-1:0][STORE_W-1:0] enable_w;
   logic [NSET-1:0][STORE_W-1:0] rise_w;
   logic [NSET-1:0][STORE_W-1:0] fall_w;

   // ==========================================================
   // command decode shared by all sets
   wire                          rd_cmd    = cmd_valid_i & ~cmd_write_i;
   wire                          wr_cmd    = cmd_valid_i & cmd_write_i;
   wire                          is_event  = (cmd_reg_i == REG_EVENT);
   wire                          is_enable = (cmd_reg_i == REG_ENABLE);
   wire                          is_rise   = (cmd_reg_i == REG_RISE);
   wire                          is_fall   = (cmd_reg_i == REG_FALL);

   genvar s;
   generate
      for (s = 0; s < NSET; s++) begin : g_set
         localparam logic [14:0] EN_PRE = (s == SET_RUN_TOP || s == SET_DQ_TOP) ? EN_PRESET_TOP : EN_PRESET_OTH;
         logic [STORE_W-1:0]     prev_r;
         logic [STORE_W-1:0]     event_r;
         logic [STORE_W-1:0]     enable_r;
         logic [STORE_W-1:0]     rise_r;
         logic [STORE_W-1:0]     fall_r;
         wire                    hit      = (cmd_set_i == SET_W'(s));
         wire                    ev_clr   = rd_cmd & hit & is_event;
         wire                    wr_en    = wr_cmd & hit & is_enable;
         wire                    wr_rise  = wr_cmd & hit & is_rise;
         wire                    wr_fall  = wr_cmd & hit & is_fall;
         wire [STORE_W-1:0]      edge_set = (cond_w[s] & ~prev_r & rise_r)
                                          | (~cond_w[s] & prev_r & fall_r);
         wire [STORE_W-1:0]      ev_nxt   = edge_set | (event_r & {STORE_W{~ev_clr}});

         assign event_w[s]  = event_r;
         assign enable_w[s] = enable_r;
         assign rise_w[s]   = rise_r;
         assign fall_w[s]   = fall_r;
         assign sum_w[s]    = |(event_r & enable_r);

         // ==========================================================
         // condition history and latched events
         always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
               prev_r  <= '0;
               event_r <= '0;
            end else begin
               prev_r  <= cond_w[s];
               event_r <= ev_nxt;
            end
         end

         // ==========================================================
         // masks and filters, preset beats a write
         always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
               enable_r <= EN_PRE;
               rise_r   <= RISE_PRESET;
               fall_r   <= FALL_PRESET;
            end else if (preset_i) begin
               enable_r <= EN_PRE;
               rise_r   <= RISE_PRESET;
               fall_r   <= FALL_PRESET;
            end else begin
               if (wr_en)
                  enable_r <= cmd_wdata_i[STORE_W-1:0];
               if (wr_rise)
                  rise_r <= cmd_wdata_i[STORE_W-1:0];
               if (wr_fall)
                  fall_r <= cmd_wdata_i[STORE_W-1:0];
            end
         end
      end
   endgenerate

   // ==========================================================
   // summary outputs
   assign summary_o = sum_w;

   // ==========================================================
   // read path
   wire                          set_ok  = (cmd_set_i < SET_W'(NSET));
   wire [SET_W-1:0]              idx     = set_ok ? cmd_set_i : '0;
   logic [STORE_W-1:0]           rd_sel;

   always_comb begin
      rd_sel = '0;
      if (set_ok) begin
         case (cmd_reg_i)
            REG_COND:   rd_sel = cond_w[idx];
            REG_EVENT:  rd_sel = event_w[idx];
            REG_ENABLE: rd_sel = enable_w[idx];
            REG_RISE:   rd_sel = rise_w[idx];
            REG_FALL:   rd_sel = fall_w[idx];
            default:    rd_sel = '0;
         endcase
      end
   end

   // ==========================================================
   // answer register
   wire                          rsp_valid_nxt = rd_cmd;
   wire [DATA_W-1:0]             rsp_data_nxt  = {1'b0, rd_sel};

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rsp_valid_o <= 1'b0;
         rsp_data_o  <= '0;
      end else begin
         rsp_valid_o <= rsp_valid_nxt;
         rsp_data_o  <= rsp_data_nxt;
      end
   end

endmodule // meter_status_regs

`default_nettype wire

// File: dv/meter_status_monitor.sv
// checker for the status register sets: read answers, readback, preset, filters
// assumes it is bound onto meter_status_regs and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module meter_status_monitor (
   input wire logic                                clk_i,
   input wire logic                                rst_n_i,
   input wire logic                                cmd_valid_i,
   input wire logic                                cmd_write_i,
   input wire logic [meter_status_pkg::SET_W-1:0]  cmd_set_i,
   input wire logic [meter_status_pkg::REG_W-1:0]  cmd_reg_i,
   input wire logic [meter_status_pkg::DATA_W-1:0] cmd_wdata_i,
   input wire logic                                preset_i,
   input wire logic [1:0]                          acq_active_i,
   input wire logic [1:0]                          sensor_read_i,
   input wire logic [1:0]                          arm_wait_i,
   input wire logic                                selftest_fail_i,
   input wire logic                                selftest_pass_i,
   input wire logic                                rsp_valid_o,
   input wire logic [meter_status_pkg::DATA_W-1:0] rsp_data_o
);
   import meter_status_pkg::*;
   // ==========================================================
   // sequences and properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_rd(logic [3:0] s, logic [2:0] r);
      cmd_valid_i && !cmd_write_i && cmd_set_i == s && cmd_reg_i == r;
   endsequence
   property p_rsp; cmd_valid_i && !cmd_write_i |=> rsp_valid_o; endproperty
   a_rsp: assert property (p_rsp) else $error("read got no answer");
   property p_bit15; rsp_valid_o |-> !rsp_data_o[15]; endproperty
   a_bit15: assert property (p_bit15) else $error("bit 15 set in answer");
   property p_unmap; cmd_valid_i && !cmd_write_i && (cmd_set_i > SET_PWR || cmd_reg_i > REG_FALL)
      |=> rsp_data_o == 16'h0000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_acq; $past(rst_n_i) ##0 s_rd(SET_ACQ, REG_COND)
      |=> rsp_data_o == {13'h0, $past(acq_active_i), 1'b0}; endproperty
   a_acq: assert property (p_acq) else $error("acquisition condition wrong");
   property p_sns; $past(rst_n_i) ##0 s_rd(SET_SNS, REG_COND)
      |=> rsp_data_o == {13'h0, $past(sensor_read_i), 1'b0}; endproperty
   a_sns: assert property (p_sns) else $error("sensor read condition wrong");
   property p_arm; $past(rst_n_i) ##0 s_rd(SET_ARM, REG_COND)
      |=> rsp_data_o == {13'h0, $past(arm_wait_i), 1'b0}; endproperty
   a_arm: assert property (p_arm) else $error("arm wait condition wrong");
   property p_st_fail; selftest_fail_i && !selftest_pass_i ##1 s_rd(SET_DQ_TOP, REG_COND) |=> rsp_data_o[9];
   endproperty
   a_st_fail: assert property (p_st_fail) else $error("self test fail not shown");
   property p_st_pass; selftest_pass_i && !selftest_fail_i ##1 s_rd(SET_DQ_TOP, REG_COND) |=> !rsp_data_o[9];
   endproperty
   a_st_pass: assert property (p_st_pass) else $error("self test pass not shown");
   property p_preset; preset_i ##1 !cmd_valid_i ##1 s_rd(SET_RUN_TOP, REG_ENABLE) |=> rsp_data_o == 16'h0000;
   endproperty
   a_preset: assert property (p_preset) else $error("top enable not cleared");
   property p_rise; cmd_valid_i && cmd_write_i && cmd_reg_i == REG_RISE && cmd_set_i <= SET_PWR && !preset_i
      ##1 !cmd_valid_i && !preset_i
      ##1 cmd_valid_i && !cmd_write_i && cmd_reg_i == REG_RISE && cmd_set_i == $past(cmd_set_i, 2)
      |=> rsp_data_o == {1'b0, $past(cmd_wdata_i[14:0], 3)}; endproperty
   a_rise: assert property (p_rise) else $error("rise filter readback wrong");
endmodule // meter_status_monitor
bind meter_status_regs meter_status_monitor i_meter_status_monitor (.clk_i, .rst_n_i, .cmd_valid_i, .cmd_write_i,
   .cmd_set_i, .cmd_reg_i, .cmd_wdata_i, .preset_i, .acq_active_i, .sensor_read_i, .arm_wait_i,
   .selftest_fail_i, .selftest_pass_i, .rsp_valid_o, .rsp_data_o);
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the status register sets
// assumes the package and the bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("ERROR %0t got %h want %h", $time, (a), (e)); end end
module tb_top;
   import meter_status_pkg::*;
   logic        clk_i = 1'b0, rst_n_i = 1'b0, cmd_valid_i = 1'b0, cmd_write_i = 1'b0, preset_i = 1'b0;
   logic        adj_err_all_i = 1'b0, selftest_fail_i = 1'b0, selftest_pass_i = 1'b0, rsp_valid_o;
   logic [3:0]  cmd_set_i = 4'h0, ul_fail_i = 4'h0, ul_pass_i = 4'h0, ul_test_en_i = 4'h0;
   logic [5:0]  ll_fail_i = 6'h00, ll_pass_i = 6'h00, ll_test_en_i = 6'h00;
   logic [1:0]  acq_active_i = 2'h0, sensor_read_i = 2'h0, arm_wait_i = 2'h0, adj_err_i = 2'h0, adj_ok_i = 2'h0;
   logic [2:0]  cmd_reg_i = 3'h0;
   logic [15:0] cmd_wdata_i = 16'h0000, rsp_data_o;
   logic [14:0] pwr_cond_i = 15'h0000;
   logic        rsp_seen;
   logic [15:0] rsp_word;
   logic [8:0]  summary_o;
   int          miscompares = 0, num_checks = 0;
   always #50 clk_i = ~clk_i;
   meter_status_regs i_meter_status_regs (.clk_i, .rst_n_i, .cmd_valid_i, .cmd_write_i, .cmd_set_i, .cmd_reg_i,
      .cmd_wdata_i, .preset_i, .ll_fail_i, .ll_pass_i, .ll_test_en_i, .ul_fail_i, .ul_pass_i, .ul_test_en_i,
      .acq_active_i, .sensor_read_i, .arm_wait_i, .pwr_cond_i, .adj_err_i, .adj_err_all_i, .adj_ok_i,
      .selftest_fail_i, .selftest_pass_i, .rsp_valid_o, .rsp_data_o, .summary_o);
   // ==========================================================
   // command tasks, driven at the falling edge
   task automatic wr(input logic w, input logic [3:0] s, input logic [2:0] r, input logic [15:0] d);
      cmd_valid_i = 1'b1;
      cmd_write_i = w;
      cmd_set_i = s;
      cmd_reg_i = r;
      cmd_wdata_i = d;
      @(negedge clk_i);
      cmd_valid_i = 1'b0;
      preset_i = 1'b0;
      rsp_seen = rsp_valid_o;
      rsp_word = rsp_data_o;
      @(negedge clk_i);
   endtask
   task automatic rd(input logic [3:0] s, input logic [2:0] r, input logic [15:0] e);
      wr(1'b0, s, r, 16'h0000);
      `CHK(rsp_seen, 1'b1)
      `CHK(rsp_word, e)
   endtask
   task automatic finish_test;
      if (miscompares == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset;
      rd(SET_RUN_TOP, REG_ENABLE, 16'h0000);
      rd(SET_LLF, REG_ENABLE, 16'h7fff);
      rd(SET_ULF, REG_FALL, 16'h0000);
      rd(4'hf, REG_COND, 16'h0000);
      rd(SET_ACQ, 3'h7, 16'h0000);
   endtask
   task automatic t_limit;
      ll_test_en_i = 6'h3f;
      ll_fail_i = 6'h20;
      ul_fail_i = 4'h8;
      @(negedge clk_i);
      ll_fail_i = 6'h00;
      ul_fail_i = 4'h0;
      repeat (2) @(negedge clk_i);
      `CHK(summary_o[SET_LLF], 1'b1)
      rd(SET_RUN_TOP, REG_COND, 16'h1800);
      rd(SET_LLF, REG_COND, 16'h0040);
      rd(SET_ULF, REG_COND, 16'h0010);
      rd(SET_LLF, REG_EVENT, 16'h0040);
      rd(SET_LLF, REG_EVENT, 16'h0000);
      ll_test_en_i = 6'h00;
      ll_pass_i = 6'h20;
      ul_pass_i = 4'h8;
      ul_test_en_i = 4'h8;
      @(negedge clk_i);
      ll_pass_i = 6'h00;
      ul_pass_i = 4'h0;
      rd(SET_LLF, REG_COND, 16'h0040);
      rd(SET_ULF, REG_COND, 16'h0000);
      ll_test_en_i = 6'h20;
      ll_pass_i = 6'h20;
      @(negedge clk_i);
      ll_pass_i = 6'h00;
      rd(SET_LLF, REG_COND, 16'h0000);
   endtask
   task automatic t_filter;
      wr(1'b1, SET_ULF, REG_RISE, 16'hffff);
      rd(SET_ULF, REG_RISE, 16'h7fff);
      wr(1'b1, SET_LLF, REG_FALL, 16'h8001);
      rd(SET_LLF, REG_FALL, 16'h0001);
      wr(1'b1, SET_RUN_TOP, REG_ENABLE, 16'h1234);
      preset_i = 1'b1;
      wr(1'b1, SET_ADJ, REG_ENABLE, 16'h0000);
      rd(SET_RUN_TOP, REG_ENABLE, 16'h0000);
      rd(SET_ULF, REG_RISE, 16'h7fff);
      rd(SET_LLF, REG_FALL, 16'h0000);
      rd(SET_ADJ, REG_ENABLE, 16'h7fff);
   endtask
   task automatic t_level;
      acq_active_i = 2'b10;
      sensor_read_i = 2'b01;
      arm_wait_i = 2'b11;
      @(negedge clk_i);
      rd(SET_ACQ, REG_COND, 16'h0004);
      rd(SET_SNS, REG_COND, 16'h0002);
      rd(SET_ARM, REG_COND, 16'h0006);
      rd(SET_ACQ, REG_EVENT, 16'h0004);
      wr(1'b1, SET_ACQ, REG_FALL, 16'h0004);
      acq_active_i = 2'b00;
      sensor_read_i = 2'b00;
      @(negedge clk_i);
      rd(SET_ACQ, REG_COND, 16'h0000);
      rd(SET_SNS, REG_COND, 16'h0000);
      rd(SET_ACQ, REG_EVENT, 16'h0004);
   endtask
   task automatic t_quality;
      selftest_fail_i = 1'b1;
      @(negedge clk_i);
      selftest_fail_i = 1'b0;
      rd(SET_DQ_TOP, REG_COND, 16'h0200);
      pwr_cond_i = 15'h0004;
      adj_err_i = 2'b10;
      @(negedge clk_i);
      adj_err_i = 2'b00;
      repeat (2) @(negedge clk_i);
      rd(SET_ADJ, REG_COND, 16'h0004);
      rd(SET_DQ_TOP, REG_COND, 16'h0308);
      adj_ok_i = 2'b10;
      @(negedge clk_i);
      adj_ok_i = 2'b00;
      rd(SET_ADJ, REG_COND, 16'h0000);
      adj_err_all_i = 1'b1;
      selftest_pass_i = 1'b1;
      @(negedge clk_i);
      adj_err_all_i = 1'b0;
      selftest_pass_i = 1'b0;
      rd(SET_DQ_TOP, REG_COND, 16'h0108);
      rd(SET_ADJ, REG_COND, 16'h0006);
   endtask
   initial begin
      repeat (6) @(negedge clk_i);
      rst_n_i = 1'b1;
      t_reset();
      t_limit();
      t_filter();
      t_level();
      t_quality();
      finish_test();
   end
   initial begin
      repeat (2000) @(posedge clk_i);
      miscompares++;
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
